// ===== hdl/lsm_mgmt.sv
/*
 Low-speed management logic of a pluggable four-lane transceiver: 2-wire
 target gated by module select, reset filter and completion interrupt,
 transmit disable, loss-of-signal alarm and monitor readout. Assumes all
 host pins are asynchronous to pclk and an APB master on pclk.
*/
// How it works
// R1: The 2-wire target only answers while module_select_n is low and goes idle otherwise.
// R2: The host gives every module its own select line and selects one at a time.
// R3: A module_reset_n low pulse longer than the minimum returns all settings to default; the code resets soft_txd, tw_ptr and flags, not int_mask or mon.
// R4: The host ignores status bits while a reset runs until completion is signalled.
// R5: Reset completion clears not-ready and drives interrupt_n low.
// R6: After power-up the completion interrupt is posted with no reset pulse.
// R7: low_power_select sets power_limit, which caps the module's power draw.
// R8: presence_n is driven low for as long as the module is powered.
// R9: The transmitter is off when the disable pin or the 2-wire control bit is set.
// R10: receive_signal_loss is high while any of the four lanes is below threshold.
// R11: Lane monitor values written by firmware are readable over the 2-wire bus.
// R12: The host reaches the memory map through serial clock and data as bus target.
// R13: Reset pulses shorter than RESET_MIN_CYC clock cycles are ignored as glitches.
`timescale 1ns/1ns
`include "lsm_regs.svh"

module lsm_mgmt #(
   parameter int RESET_MIN_CYC = `LSM_RESET_MIN_CYC,
   parameter logic [6:0] TW_DEV_ADDR = `LSM_TW_DEV_ADDR
) (
   // Clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // APB slave
   input wire logic [7:0] paddr,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   output logic irq,
   // Host management pins
   input wire logic module_select_n,
   input wire logic module_reset_n,
   input wire logic low_power_select,
   input wire logic scl,
   input wire logic sda_in,
   output logic sda_out,
   output logic sda_oe,
   output logic interrupt_n,
   output logic presence_n,
   // Optical side
   input wire logic transmit_disable,
   input wire logic [`LSM_LANES-1:0] lane_signal_low,
   output logic tx_off,
   output logic receive_signal_loss,
   output logic power_limit
);
   import lsm_pkg::*;

   if (RESET_MIN_CYC < 2 || RESET_MIN_CYC > 65535) begin : g_bad_min
      $error("RESET_MIN_CYC out of range");
   end

   localparam logic [15:0] RST_LAST = 16'(RESET_MIN_CYC - 1);

   lsm_state_type r_reg;
   lsm_state_type r_next;

   // Byte of the 2-wire memory map at address a
   function automatic logic [7:0] mem_byte(input logic [7:0] a, input lsm_state_type s);
      logic [7:0] b;
      b = 8'h00;
      case (a)
         `LSM_TW_STATUS: b = {6'h00, s.host_int, s.not_ready};
         `LSM_TW_LOS: b = {4'h0, s.los2};
         `LSM_TW_CTRL: b = {7'h00, s.soft_txd};
         `LSM_TW_MON0: b = s.mon[7:0]; // R11
         `LSM_TW_MON1: b = s.mon[15:8];
         `LSM_TW_MON2: b = s.mon[23:16];
         `LSM_TW_MON3: b = s.mon[31:24];
         default: b = 8'h00;
      endcase
      return b;
   endfunction : mem_byte

   // APB offset decode, shared by read and write
   function automatic logic apb_hit(input logic [7:0] a);
      return a == `LSM_STATUS_OFS || a == `LSM_INT_STS_OFS ||
         a == `LSM_INT_MASK_OFS || a == `LSM_MON_OFS;
   endfunction : apb_hit

   always_comb begin
      logic selected;
      logic scl_rise;
      logic scl_fall;
      logic sda_bit;
      logic start_c;
      logic stop_c;
      logic apb_acc;
      logic [2:0] evt;
      logic [2:0] clr;
      logic [7:0] b;
      logic [7:0] nptr;
      selected = 1'b0;
      scl_rise = 1'b0;
      scl_fall = 1'b0;
      sda_bit = 1'b0;
      start_c = 1'b0;
      stop_c = 1'b0;
      apb_acc = 1'b0;
      evt = 3'h0;
      clr = 3'h0;
      b = 8'h00;
      nptr = 8'h00;
      r_next = r_reg;

      // Synchronisers; only the second stage and the delayed copy are used
      r_next.scl_sy = {r_reg.scl_sy[1:0], scl};
      r_next.sda_sy = {r_reg.sda_sy[1:0], sda_in};
      r_next.sel_sy = {r_reg.sel_sy[0], module_select_n};
      r_next.rst_sy = {r_reg.rst_sy[0], module_reset_n};
      r_next.lp_sy = {r_reg.lp_sy[0], low_power_select};
      r_next.txd_sy = {r_reg.txd_sy[0], transmit_disable};
      r_next.los1 = lane_signal_low;
      r_next.los2 = r_reg.los1;
      r_next.los_prev = r_reg.los2;

      selected = ~r_reg.sel_sy[1];
      scl_rise = r_reg.scl_sy[1] & ~r_reg.scl_sy[2];
      scl_fall = ~r_reg.scl_sy[1] & r_reg.scl_sy[2];
      sda_bit = r_reg.sda_sy[1];
      start_c = r_reg.scl_sy[1] & r_reg.scl_sy[2] & ~r_reg.sda_sy[1] & r_reg.sda_sy[2];
      stop_c = r_reg.scl_sy[1] & r_reg.scl_sy[2] & r_reg.sda_sy[1] & ~r_reg.sda_sy[2];

      // 2-wire target; scl sampled at 4 ns keeps up with the 64 ns bit period of the host model
      if (!selected || stop_c || r_reg.rs_state == LSM_RS_HOLD) begin
         r_next.tw_phase = LSM_TW_IDLE; // R1
         r_next.sda_oe = 1'b0;
      end else if (start_c) begin
         r_next.tw_phase = LSM_TW_ADDR; // R12
         r_next.tw_cnt = 4'h0;
         r_next.tw_first = 1'b1;
         r_next.sda_oe = 1'b0;
      end else if (r_reg.tw_phase != LSM_TW_IDLE) begin
         if (scl_rise) begin
            if (r_reg.tw_cnt < 4'h8) begin
               if (r_reg.tw_phase == LSM_TW_READ) begin
                  r_next.tw_sh = {r_reg.tw_sh[6:0], 1'b0};
               end else begin
                  r_next.tw_sh = {r_reg.tw_sh[6:0], sda_bit};
               end
               r_next.tw_cnt = r_reg.tw_cnt + 4'h1;
            end else if (r_reg.tw_phase == LSM_TW_READ) begin
               // Master ack low asks for the next byte, high ends the read
               if (sda_bit) begin
                  r_next.tw_phase = LSM_TW_IDLE;
               end else begin
                  nptr = r_reg.tw_ptr + 8'h01;
                  r_next.tw_ptr = nptr;
                  r_next.tw_sh = mem_byte(nptr, r_reg); // R11
                  r_next.tw_cnt = 4'h0;
                  if (nptr == `LSM_TW_STATUS) begin
                     r_next.host_int = 1'b0;
                  end
               end
            end
         end else if (scl_fall) begin
            case (r_reg.tw_cnt)
               4'h8: begin
                  if (r_reg.tw_phase == LSM_TW_READ) begin
                     r_next.sda_oe = 1'b0;
                  end else if (r_reg.tw_phase == LSM_TW_ADDR) begin
                     if (r_reg.tw_sh[7:1] == TW_DEV_ADDR) begin
                        r_next.sda_oe = 1'b1; // R12
                        r_next.tw_rw = r_reg.tw_sh[0];
                        r_next.tw_cnt = 4'h9;
                     end else begin
                        r_next.tw_phase = LSM_TW_IDLE;
                     end
                  end else begin
                     if (r_reg.tw_first) begin
                        r_next.tw_ptr = r_reg.tw_sh;
                        r_next.tw_first = 1'b0;
                     end else begin
                        if (r_reg.tw_ptr == `LSM_TW_CTRL) begin
                           r_next.soft_txd = r_reg.tw_sh[0]; // R9
                        end
                        r_next.tw_ptr = r_reg.tw_ptr + 8'h01;
                        evt[`LSM_EV_HOST_WRITE] = 1'b1;
                     end
                     r_next.sda_oe = 1'b1;
                     r_next.tw_cnt = 4'h9;
                  end
               end
               4'h9: begin
                  r_next.tw_cnt = 4'h0;
                  if (r_reg.tw_phase == LSM_TW_ADDR && r_reg.tw_rw) begin
                     b = mem_byte(r_reg.tw_ptr, r_reg);
                     r_next.tw_phase = LSM_TW_READ;
                     r_next.tw_sh = b;
                     r_next.sda_oe = ~b[7];
                     if (r_reg.tw_ptr == `LSM_TW_STATUS) begin
                        r_next.host_int = 1'b0;
                     end
                  end else begin
                     r_next.tw_phase = LSM_TW_WRITE;
                     r_next.sda_oe = 1'b0;
                  end
               end
               default: begin
                  if (r_reg.tw_phase == LSM_TW_READ) begin
                     r_next.sda_oe = ~r_reg.tw_sh[7];
                  end
               end
            endcase
         end
      end

      // Reset sequencer; the power-on state is INIT, so completion posts alone
      case (r_reg.rs_state)
         LSM_RS_HOLD: begin
            if (r_reg.rst_sy[1]) begin
               r_next.rs_state = LSM_RS_INIT;
            end
         end
         LSM_RS_INIT: begin
            r_next.not_ready = 1'b0; // R5
            r_next.host_int = 1'b1; // R6
            evt[`LSM_EV_RESET_DONE] = 1'b1;
            r_next.rs_state = LSM_RS_RUN;
         end
         LSM_RS_RUN: begin
            r_next.rs_state = LSM_RS_RUN;
         end
         default: begin
            r_next.rs_state = LSM_RS_INIT;
         end
      endcase

      // Low-time filter on module_reset_n
      if (r_reg.rst_sy[1]) begin
         r_next.rst_cnt = 16'h0000;
      end else if (r_reg.rst_cnt != RST_LAST + 16'h0001) begin
         r_next.rst_cnt = r_reg.rst_cnt + 16'h0001; // R13
      end
      if (!r_reg.rst_sy[1] && r_reg.rst_cnt == RST_LAST) begin
         r_next.rs_state = LSM_RS_HOLD; // R3
         r_next.not_ready = 1'b1;
         r_next.host_int = 1'b0;
         r_next.soft_txd = 1'b0;
         r_next.tw_ptr = 8'h00;
      end

      // Pin-facing levels
      r_next.tx_off = r_reg.txd_sy[1] | r_reg.soft_txd; // R9
      r_next.rx_loss = |r_reg.los2; // R10
      if (|(r_reg.los2 & ~r_reg.los_prev)) begin
         evt[`LSM_EV_LOS_RISE] = 1'b1;
      end
      r_next.power_limit = r_reg.lp_sy[1]; // R7
      r_next.int_n = ~r_reg.host_int; // R5
      r_next.prs_n = 1'b0; // R8
      r_next.sda_o = 1'b0;

      // APB: one wait-free access phase, data prepared during setup
      r_next.pready = psel & ~penable;
      apb_acc = psel & penable & r_reg.pready;
      if (psel && !penable) begin
         r_next.pslverr = ~apb_hit(paddr);
         case (paddr)
            `LSM_STATUS_OFS: r_next.prdata = {20'h00000, r_reg.los2, 2'h0, r_reg.power_limit,
               r_reg.tx_off, r_reg.soft_txd, r_reg.host_int, r_reg.not_ready, selected};
            `LSM_INT_STS_OFS: r_next.prdata = {29'h00000000, r_reg.int_sts};
            `LSM_INT_MASK_OFS: r_next.prdata = {29'h00000000, r_reg.int_mask};
            `LSM_MON_OFS: r_next.prdata = r_reg.mon;
            default: r_next.prdata = 32'h00000000;
         endcase
      end else if (apb_acc) begin
         r_next.pslverr = 1'b0;
      end
      if (apb_acc && pwrite) begin
         case (paddr)
            `LSM_INT_STS_OFS: clr = pwdata[2:0];
            `LSM_INT_MASK_OFS: r_next.int_mask = pwdata[2:0];
            `LSM_MON_OFS: r_next.mon = pwdata;
            default: clr = 3'h0;
         endcase
      end
      // A new event wins over a clear in the same cycle
      r_next.int_sts = (r_reg.int_sts & ~clr) | evt;
      r_next.irq = |(r_next.int_sts & r_next.int_mask);
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         r_reg <= '0;
         r_reg.scl_sy <= 3'h7;
         r_reg.sda_sy <= 3'h7;
         r_reg.sel_sy <= 2'h3;
         r_reg.rst_sy <= 2'h3;
         r_reg.rs_state <= LSM_RS_INIT;
         r_reg.not_ready <= 1'b1;
         r_reg.int_mask <= `LSM_INT_MASK_RST;
         r_reg.int_n <= 1'b1;
      end else begin
         r_reg <= r_next;
      end
   end

   assign prdata = r_reg.prdata;
   assign pready = r_reg.pready;
   assign pslverr = r_reg.pslverr;
   assign irq = r_reg.irq;
   assign sda_out = r_reg.sda_o;
   assign sda_oe = r_reg.sda_oe;
   assign interrupt_n = r_reg.int_n;
   assign presence_n = r_reg.prs_n;
   assign tx_off = r_reg.tx_off;
   assign receive_signal_loss = r_reg.rx_loss;
   assign power_limit = r_reg.power_limit;

endmodule : lsm_mgmt

// ===== hdl/lsm_pkg.sv
/*
 Types of the low-speed management block: state encodings and the packed
 state record. Assumes lsm_regs.svh for the lane count.
*/
`include "lsm_regs.svh"

package lsm_pkg;

   typedef enum logic [1:0] {
      LSM_RS_INIT = 2'b00,
      LSM_RS_RUN = 2'b01,
      LSM_RS_HOLD = 2'b10
   } lsm_rs_type;

   typedef enum logic [1:0] {
      LSM_TW_IDLE = 2'b00,
      LSM_TW_ADDR = 2'b01,
      LSM_TW_WRITE = 2'b10,
      LSM_TW_READ = 2'b11
   } lsm_tw_type;

   typedef struct packed {
      logic [2:0] scl_sy;
      logic [2:0] sda_sy;
      logic [1:0] sel_sy;
      logic [1:0] rst_sy;
      logic [1:0] lp_sy;
      logic [1:0] txd_sy;
      logic [`LSM_LANES-1:0] los1;
      logic [`LSM_LANES-1:0] los2;
      logic [`LSM_LANES-1:0] los_prev;
      lsm_rs_type rs_state;
      logic [15:0] rst_cnt;
      logic not_ready;
      logic host_int;
      logic soft_txd;
      lsm_tw_type tw_phase;
      logic [3:0] tw_cnt;
      logic [7:0] tw_sh;
      logic tw_rw;
      logic tw_first;
      logic [7:0] tw_ptr;
      logic sda_oe;
      logic sda_o;
      logic [31:0] mon;
      logic [2:0] int_sts;
      logic [2:0] int_mask;
      logic irq;
      logic tx_off;
      logic rx_loss;
      logic power_limit;
      logic int_n;
      logic prs_n;
      logic pready;
      logic pslverr;
      logic [31:0] prdata;
   } lsm_state_type;

endpackage : lsm_pkg

// ===== hdl/lsm_regs.svh
/*
 Register offsets, field positions, reset values and timing counts of the
 low-speed management block. Assumes byte addressing on the APB side.
*/
`ifndef LSM_REGS_SVH
`define LSM_REGS_SVH

// APB register byte offsets
`define LSM_STATUS_OFS 8'h00
`define LSM_INT_STS_OFS 8'h04
`define LSM_INT_MASK_OFS 8'h08
`define LSM_MON_OFS 8'h0C

// Event bits of status and mask registers
`define LSM_EV_RESET_DONE 0
`define LSM_EV_LOS_RISE 1
`define LSM_EV_HOST_WRITE 2
`define LSM_INT_MASK_RST 3'h0

// 2-wire memory map byte addresses
`define LSM_TW_STATUS 8'h00
`define LSM_TW_LOS 8'h01
`define LSM_TW_CTRL 8'h02
`define LSM_TW_MON0 8'h03
`define LSM_TW_MON1 8'h04
`define LSM_TW_MON2 8'h05
`define LSM_TW_MON3 8'h06

// Defaults of module parameters and the lane count
`define LSM_RESET_MIN_CYC 16
`define LSM_TW_DEV_ADDR 7'h50
`define LSM_LANES 4

`endif

// ===== sim/lsm_host_model.sv
/*
 Behavioural host controller on the 2-wire management bus, 64 ns bit period.
 Assumes the bench resolves sda with a pull-up; released here means 1.
*/
`timescale 1ns/1ns
module lsm_host_model (
   // Resolved data wire
   input wire logic sda_line,
   // Host drives
   output logic scl,
   output logic sda_drv
);
   // Clock stands high between frames
   initial begin
      scl = 1'b1;
      sda_drv = 1'b1;
   end
   task automatic start();
      sda_drv = 1'b1;
      #16 scl = 1'b1;
      #16 sda_drv = 1'b0;
      #16 scl = 1'b0;
      #16;
   endtask : start
   // Nine clocks; bit 9 is released on writes, host ack or nack on reads
   task automatic xb(input logic [7:0] tx, input logic mack, output logic [7:0] rx,
      output logic ack);
      for (int i = 0; i < 9; i++) begin
         sda_drv = (i < 8) ? tx[7 - i] : mack;
         #16 scl = 1'b1;
         #16;
         if (i < 8)
            rx[7 - i] = sda_line;
         else
            ack = sda_line;
         #16 scl = 1'b0;
         #16;
      end
   endtask : xb
   task automatic stop();
      sda_drv = 1'b0;
      #16 scl = 1'b1;
      #16 sda_drv = 1'b1;
      #16;
   endtask : stop
endmodule : lsm_host_model

// ===== sim/lsm_mgmt_props.sv
/*
 Pin-level checker of the low-speed management block.
 Assumes binding to lsm_mgmt, all checks on pclk with presetn as reset.
*/
`timescale 1ns/1ns
`include "lsm_regs.svh"
module lsm_mgmt_props #(
   parameter int RESET_MIN_CYC = 16
) (
   // Clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // Host pins
   input wire logic module_select_n,
   input wire logic module_reset_n,
   input wire logic low_power_select,
   input wire logic scl,
   input wire logic sda_out,
   input wire logic sda_oe,
   input wire logic interrupt_n,
   input wire logic presence_n,
   // Optical side
   input wire logic transmit_disable,
   input wire logic [`LSM_LANES-1:0] lane_signal_low,
   input wire logic tx_off,
   input wire logic receive_signal_loss,
   input wire logic power_limit
);
   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);
   logic [15:0] low_cnt;
   // Saturating count of low reset-pin cycles; margin of 5 covers the synchroniser
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn)
         low_cnt <= 16'h0000;
      else if (module_reset_n)
         low_cnt <= 16'h0000;
      else if (low_cnt != 16'hFFFF)
         low_cnt <= low_cnt + 16'h0001;
   end
   sequence s_deselected;
      module_select_n [*6];
   endsequence
   sequence s_reset_held;
      low_cnt > RESET_MIN_CYC + 5;
   endsequence
   sequence s_reset_end;
      module_reset_n && low_cnt > RESET_MIN_CYC + 5;
   endsequence
   sel_gate_a: assert property (s_deselected |-> !sda_oe)
      else $error("sda pulled while deselected");
   rst_hold_a: assert property (s_reset_held |-> interrupt_n && !sda_oe)
      else $error("reset hold left interrupt or sda active");
   rst_done_a: assert property (s_reset_end |-> ##[1:8] !interrupt_n)
      else $error("no completion interrupt after reset");
   int_post_a: assert property ($rose(presetn) |-> ##[1:4] !interrupt_n)
      else $error("no completion interrupt after power-up");
   present_a: assert property ($past(presetn) |-> !presence_n)
      else $error("presence not driven low");
   transmit_disable_a: assert property (transmit_disable [*5] |-> tx_off)
      else $error("transmitter on while disable pin high");
   los_lvl_a: assert property ($stable(lane_signal_low) [*5] |->
      receive_signal_loss == (|lane_signal_low))
      else $error("loss alarm differs from lane levels");
   pwr_lim_a: assert property ($stable(low_power_select) [*5] |->
      power_limit == low_power_select)
      else $error("power limit differs from select pin");
   open_drain_a: assert property (sda_oe |-> !sda_out)
      else $error("sda driven high");
   no_start_a: assert property ($rose(sda_oe) |-> !scl)
      else $error("sda pulled while scl high");
endmodule : lsm_mgmt_props

bind lsm_mgmt lsm_mgmt_props #(.RESET_MIN_CYC(RESET_MIN_CYC)) u_props (.pclk, .presetn,
   .module_select_n, .module_reset_n, .low_power_select, .scl, .sda_out, .sda_oe,
   .interrupt_n, .presence_n, .transmit_disable, .lane_signal_low, .tx_off,
   .receive_signal_loss, .power_limit);

// ===== sim/lsm_mgmt_tb.sv
/*
 Self-checking bench of lsm_mgmt: APB tasks, 2-wire host model, pin stimulus.
 Assumes the host model and the bound checker are compiled alongside.
*/
`timescale 1ns/1ns
`include "lsm_regs.svh"
module lsm_mgmt_tb;
   logic pclk, presetn, psel, penable, pwrite, pready, pslverr, irq, err, ack;
   logic [7:0] paddr, rx;
   logic [31:0] pwdata, prdata, r;
   logic module_select_n, module_reset_n, low_power_select, scl, hm_sda;
   logic sda_out, sda_oe, interrupt_n, presence_n, transmit_disable;
   logic tx_off, receive_signal_loss, power_limit;
   logic [3:0] lane_signal_low;
   wire logic sda_in = hm_sda & ~(sda_oe & ~sda_out);
   int fails, samples_checked;

   lsm_mgmt #(.RESET_MIN_CYC(4)) DUT (.pclk, .presetn, .paddr, .psel, .penable, .pwrite,
      .pwdata, .prdata, .pready, .pslverr, .irq, .module_select_n, .module_reset_n,
      .low_power_select, .scl, .sda_in, .sda_out, .sda_oe, .interrupt_n, .presence_n,
      .transmit_disable, .lane_signal_low, .tx_off, .receive_signal_loss, .power_limit);
   lsm_host_model hm (.sda_line(sda_in), .scl(scl), .sda_drv(hm_sda));

   task automatic end_sim();
      $display("fails=%0d samples_checked=%0d", fails, samples_checked);
      if (fails == 0 && samples_checked > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask : end_sim
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      samples_checked++;
      if (got !== exp) begin
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
         fails++;
      end
   endtask : chk
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int n;
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 16);
      if (pready !== 1'b1) begin
         $display("BAD t=%0t got=%h exp=%h", $time, pready, 1'b1);
         fails++;
         end_sim();
      end else begin
         r = prdata;
         err = pslverr;
         psel <= 1'b0;
         penable <= 1'b0;
      end
   endtask : apb
   task automatic tw_wr(input logic [7:0] p, input logic [7:0] d);
      hm.start();
      hm.xb({`LSM_TW_DEV_ADDR, 1'b0}, 1'b1, rx, ack);
      hm.xb(p, 1'b1, rx, ack);
      hm.xb(d, 1'b1, rx, ack);
      hm.stop();
   endtask : tw_wr
   task automatic tw_rd(input logic [7:0] p);
      hm.start();
      hm.xb({`LSM_TW_DEV_ADDR, 1'b0}, 1'b1, rx, ack);
      hm.xb(p, 1'b1, rx, ack);
      hm.start();
      hm.xb({`LSM_TW_DEV_ADDR, 1'b1}, 1'b1, rx, ack);
      hm.xb(8'hFF, 1'b1, rx, ack);
      hm.stop();
   endtask : tw_rd

   initial begin
      pclk = 1'b0;
      forever #2 pclk = ~pclk;
   end
   initial begin
      fails = 0;
      samples_checked = 0;
      {presetn, psel, penable, pwrite, paddr, pwdata} = '0;
      {module_reset_n, low_power_select, transmit_disable, lane_signal_low} = 7'h40;
      module_select_n = 1'b1;
      repeat (2) @(posedge pclk);
      presetn <= 1'b1;
      repeat (6) @(posedge pclk);
      chk(interrupt_n, 1'b0);
      chk(presence_n, 1'b0);
      apb(1'b0, `LSM_STATUS_OFS, 32'h0);
      chk(r[1], 1'b0);
      apb(1'b0, `LSM_INT_STS_OFS, 32'h0);
      chk(r, 32'h1);
      apb(1'b1, `LSM_INT_MASK_OFS, 32'h1);
      repeat (2) @(posedge pclk);
      chk(irq, 1'b1);
      apb(1'b1, `LSM_INT_STS_OFS, 32'h1);
      repeat (2) @(posedge pclk);
      chk(irq, 1'b0);
      apb(1'b0, 8'h10, 32'h0);
      chk({err, r}, {1'b1, 32'h0});
      $display("power-up and interrupt test done");
      for (int i = 0; i < 4; i++) begin
         lane_signal_low <= 4'h1 << i;
         repeat (6) @(posedge pclk);
         chk(receive_signal_loss, 1'b1);
         lane_signal_low <= 4'h0;
         repeat (6) @(posedge pclk);
         chk(receive_signal_loss, 1'b0);
      end
      apb(1'b0, `LSM_INT_STS_OFS, 32'h0);
      chk(r, 32'h2);
      low_power_select <= 1'b1;
      transmit_disable <= 1'b1;
      repeat (6) @(posedge pclk);
      chk({power_limit, tx_off}, 2'h3);
      low_power_select <= 1'b0;
      transmit_disable <= 1'b0;
      repeat (6) @(posedge pclk);
      chk({power_limit, tx_off}, 2'h0);
      $display("pin test done");
      tw_wr(`LSM_TW_CTRL, 8'h01);
      chk({ack, tx_off}, 2'h2);
      @(posedge pclk);
      module_select_n <= 1'b0;
      repeat (4) @(posedge pclk);
      tw_wr(`LSM_TW_CTRL, 8'h01);
      repeat (4) @(posedge pclk);
      chk({ack, tx_off}, 2'h1);
      apb(1'b0, `LSM_STATUS_OFS, 32'h0);
      chk(r, 32'h1D);
      apb(1'b0, `LSM_INT_STS_OFS, 32'h0);
      chk(r, 32'h6);
      apb(1'b1, `LSM_MON_OFS, 32'h44332211);
      for (int i = 0; i < 4; i++) begin
         tw_rd(`LSM_TW_MON0 + i[7:0]);
         chk(rx, 32'h11 * (i + 1));
      end
      // Two-byte read: host ack after the first byte moves to the next lane
      hm.start();
      hm.xb({`LSM_TW_DEV_ADDR, 1'b0}, 1'b1, rx, ack);
      hm.xb(`LSM_TW_MON0, 1'b1, rx, ack);
      hm.start();
      hm.xb({`LSM_TW_DEV_ADDR, 1'b1}, 1'b1, rx, ack);
      hm.xb(8'hFF, 1'b0, rx, ack);
      chk(rx, 32'h11);
      hm.xb(8'hFF, 1'b1, rx, ack);
      hm.stop();
      chk(rx, 32'h22);
      // A foreign device address must not be acknowledged
      hm.start();
      hm.xb({`LSM_TW_DEV_ADDR ^ 7'h01, 1'b0}, 1'b1, rx, ack);
      hm.stop();
      chk(ack, 1'b1);
      tw_rd(`LSM_TW_STATUS);
      repeat (4) @(posedge pclk);
      chk({rx[1:0], interrupt_n}, 3'h5);
      $display("serial test done");
      module_reset_n <= 1'b0;
      repeat (2) @(posedge pclk);
      module_reset_n <= 1'b1;
      repeat (8) @(posedge pclk);
      chk({interrupt_n, tx_off}, 2'h3);
      module_reset_n <= 1'b0;
      repeat (12) @(posedge pclk);
      chk(interrupt_n, 1'b1);
      module_reset_n <= 1'b1;
      repeat (8) @(posedge pclk);
      chk({interrupt_n, tx_off}, 2'h0);
      apb(1'b0, `LSM_STATUS_OFS, 32'h0);
      chk(r[3:1], 3'h2);
      $display("module reset test done");
      end_sim();
   end
endmodule : lsm_mgmt_tb
